/* verilog/memory_map_wait_state_decoder.sv */
/*
  Program and data memory map decoder with wait-state strobe sequencing,
  the three mapped control registers, interrupt merge and clock gating.
  Assumes the core issues an access as a one-cycle valid and waits for ack.
*/
`timescale 1ns/100ps
`default_nettype none

module memory_map_wait_state_decoder
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic map_select_pin_i,
  input wire logic boot_select_pin_i,
  input wire map_select_pin_pkg::mem_req_t pm_req_i,
  input wire map_select_pin_pkg::mem_req_t dm_req_i,
  input wire logic [map_select_pin_pkg::PM_DATA_W-1:0] ext_data_i,
  input wire logic [map_select_pin_pkg::N_PERIPH_IRQ-1:0] periph_irq_src_i,
  input wire logic [map_select_pin_pkg::N_CORE_IRQ-1:0] core_irq_src_i,
  input wire logic [map_select_pin_pkg::N_CORE_IRQ-1:0] core_irq_mask_i,
  output var map_select_pin_pkg::ext_bus_t ext_bus_o,
  output var logic busy_o,
  output var logic ack_o,
  output var logic [map_select_pin_pkg::PM_DATA_W-1:0] rdata_o,
  output var map_select_pin_pkg::target_t target_o,
  output var logic vector_space_o,
  output var logic rom_select_bit_o,
  output var logic monitor_available_o,
  output var logic [map_select_pin_pkg::ADDR_W-1:0] start_addr_o,
  output var logic boot_load_o,
  output var logic peripheral_interrupt_line_o,
  output var logic irq_pending_o,
  output var logic [map_select_pin_pkg::IRQ_IDX_W-1:0] irq_index_o,
  output var logic instruction_clock_out_o,
  output var logic periph_clk_en_o,
  output var logic watchdog_clk_en_o
);
  import map_select_pin_pkg::*;

  acc_state_t state;
  logic [DM_DATA_W-1:0] data_wait_register;
  logic [DM_DATA_W-1:0] serial_autobuffer_control;
  logic [WAIT_W-1:0] program_wait_count;
  mem_req_t dm_pend;
  logic cur_is_dm;
  logic wait_last;

  // ----------------------------------------------------------------
  // mode straps and register fields
  // ----------------------------------------------------------------
  wire map_mode_t mode = map_mode_t'({map_select_pin_i, boot_select_pin_i});
  wire standalone = (mode == MODE_STANDALONE);
  wire ram_high = (mode == MODE_NO_BOOT);
  wire rom_select_bit = data_wait_register[ROM_SEL_BIT];
  wire clock_output_disable = serial_autobuffer_control[CLOCK_OUTPUT_DISABLE_BIT];

  // ----------------------------------------------------------------
  // request selection: program first, then data
  // ----------------------------------------------------------------
  wire sel_is_pm = pm_req_i.valid;
  wire mem_req_t sel_req = sel_is_pm ? pm_req_i : (dm_pend.valid ? dm_pend : dm_req_i);
  wire [ADDR_W-1:0] sa = sel_req.addr;
  wire take = (state == ST_IDLE) && sel_req.valid;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire pm_ram_hit = ram_high ? in_range(sa, PM_RAM_HIGH_BASE, ADDR_TOP) // RULE_05
                             : in_range(sa, PM_RAM_LOW_BASE, PM_RAM_LOW_LAST); // RULE_03
  wire pm_rom_hit = rom_select_bit && in_range(sa, PM_ROM_BASE, PM_ROM_LAST) && !pm_ram_hit; // RULE_01
  wire dm_ram_hit = in_range(sa, DM_RAM_BASE, DM_RAM_LAST); // RULE_08
  wire dm_periph_hit = in_range(sa, DM_PERIPH_BASE, DM_PERIPH_LAST);
  wire dm_core_hit = in_range(sa, DM_CORE_BASE, ADDR_TOP);
  wire vector_hit = in_range(sa, PM_RAM_LOW_BASE, PM_VECTOR_LAST); // RULE_06

  wire target_t pm_tgt = pm_ram_hit ? TGT_PM_RAM : (pm_rom_hit ? TGT_PM_ROM : TGT_PM_EXT);
  wire target_t dm_tgt = dm_ram_hit ? TGT_DM_RAM : (dm_periph_hit ? TGT_DM_PERIPH :
                         (dm_core_hit ? TGT_DM_CORE : TGT_DM_EXT));
  wire target_t sel_tgt = sel_is_pm ? pm_tgt : dm_tgt;
  wire sel_ext = (sel_tgt == TGT_PM_EXT) || (sel_tgt == TGT_DM_EXT);

  // each external data region has its own wait field
  wire [WAIT_W-1:0] dm_wait_sel = // RULE_09
    in_range(sa, DM_WAIT_E_BASE, DM_EXT_TOP) ? data_wait_register[DW_E_LSB +: WAIT_W] :
    in_range(sa, DM_WAIT_C_BASE, DM_EXT_TOP) ? data_wait_register[DW_C_LSB +: WAIT_W] :
    in_range(sa, DM_WAIT_D_BASE, DM_EXT_TOP) ? data_wait_register[DW_D_LSB +: WAIT_W] :
    in_range(sa, DM_WAIT_B_BASE, DM_EXT_TOP) ? data_wait_register[DW_B_LSB +: WAIT_W] :
                                               data_wait_register[DW_A_LSB +: WAIT_W];
  wire [WAIT_W-1:0] sel_wait = sel_is_pm ? program_wait_count : dm_wait_sel; // RULE_07

  // data memory words ride on the upper sixteen data lines
  wire [PM_DATA_W-1:0] ext_wdata = sel_is_pm ? sel_req.wdata
                                             : {sel_req.wdata[DM_DATA_W-1:0], {DM_LANE_LSB{1'b0}}};
  wire ext_bus_t next_bus = '{pms_n: !sel_is_pm, dms_n: sel_is_pm, rd_n: sel_req.write,
                              wr_n: !sel_req.write, addr: sa, addr_oe: 1'b1,
                              data: ext_wdata, data_oe: sel_req.write};

  // ----------------------------------------------------------------
  // register access from the core data bus
  // ----------------------------------------------------------------
  wire reg_wr = take && !sel_is_pm && sel_req.write;
  wire wr_wait = reg_wr && (sa == DATA_WAIT_ADDR);
  wire wr_autobuf = reg_wr && (sa == AUTOBUF_CTRL_ADDR);
  wire wr_sysctl = reg_wr && (sa == SYS_CTRL_ADDR);
  wire [DM_DATA_W-1:0] sysctl_view = {{(DM_DATA_W-WAIT_W){1'b0}}, program_wait_count};
  wire [DM_DATA_W-1:0] reg_rdata = (sa == DATA_WAIT_ADDR) ? data_wait_register :
                                   (sa == AUTOBUF_CTRL_ADDR) ? serial_autobuffer_control :
                                   (sa == SYS_CTRL_ADDR) ? sysctl_view : '0;
  wire [PM_DATA_W-1:0] int_rdata = (!sel_is_pm && dm_core_hit)
                                   ? {{(PM_DATA_W-DM_DATA_W){1'b0}}, reg_rdata} : '0;
  wire [PM_DATA_W-1:0] ext_dm_rdata = {{(PM_DATA_W-DM_DATA_W){1'b0}}, ext_data_i[PM_DATA_W-1:DM_LANE_LSB]};
  wire [DM_DATA_W-1:0] init_wait = standalone ? ROM_SEL_ONLY : (data_wait_register & DATA_WAIT_FIELDS);

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_wait_register <= DATA_WAIT_RESET; // RULE_09
      serial_autobuffer_control <= AUTOBUF_RESET;
      program_wait_count <= WAIT_RESET; // RULE_07
    end
    else if (ce_i)
    begin
      // straps are caught after release, never under the asynchronous reset
      if (state == ST_INIT)
        data_wait_register <= init_wait; // RULE_02 RULE_11
      else if (wr_wait)
        data_wait_register <= sel_req.wdata[DM_DATA_W-1:0];
      if (wr_autobuf)
        serial_autobuffer_control <= sel_req.wdata[DM_DATA_W-1:0];
      if (wr_sysctl)
        program_wait_count <= sel_req.wdata[PROGRAM_WAIT_COUNT_LSB +: WAIT_W];
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  wait_state_counter u_wait
  (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .load_i(take && sel_ext),
    .count_i(sel_wait),
    .last_o(wait_last)
  );

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_INIT;
      ext_bus_o <= EXT_IDLE;
      busy_o <= 1'b1;
      ack_o <= 1'b0;
      rdata_o <= '0;
      target_o <= TGT_NONE;
      vector_space_o <= 1'b0;
      cur_is_dm <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_o <= 1'b0;
      case (state)
        ST_INIT:
        begin
          state <= ST_IDLE;
          busy_o <= 1'b0;
        end
        ST_IDLE:
        if (take)
        begin
          target_o <= sel_tgt;
          vector_space_o <= sel_is_pm && vector_hit; // RULE_06
          cur_is_dm <= !sel_is_pm;
          if (sel_ext)
          begin
            ext_bus_o <= next_bus;
            busy_o <= 1'b1;
            state <= ST_EXT;
          end
          else
          begin
            ack_o <= 1'b1; // RULE_19
            rdata_o <= int_rdata;
          end
        end
        ST_EXT:
        if (wait_last)
        begin
          ext_bus_o <= EXT_IDLE; // RULE_20
          ack_o <= 1'b1;
          busy_o <= 1'b0;
          rdata_o <= cur_is_dm ? ext_dm_rdata : ext_data_i;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // a data access that loses to a program fetch is parked, not dropped
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      dm_pend <= REQ_NONE;
    else if (ce_i)
    begin
      if (take && sel_is_pm && dm_req_i.valid)
        dm_pend <= dm_req_i;
      else if (take && !sel_is_pm)
        dm_pend <= REQ_NONE;
    end
  end

  // ----------------------------------------------------------------
  // mode outputs, interrupts and clocks
  // ----------------------------------------------------------------
  wire [N_CORE_IRQ-1:0] core_vec = core_irq_src_i & ~(N_CORE_IRQ'(1) << IRQ_PERIPH_IDX)
                                   | ({{(N_CORE_IRQ-1){1'b0}}, peripheral_interrupt_line_o} << IRQ_PERIPH_IDX);
  wire [N_CORE_IRQ-1:0] eligible = core_vec & (core_irq_mask_i | NMI_MASK); // RULE_12
  logic [IRQ_IDX_W-1:0] next_irq_index;

  // lowest index wins
  always_comb
  begin
    next_irq_index = '0;
    for (int i = N_CORE_IRQ - 1; i >= 0; i--)
      if (eligible[i])
        next_irq_index = IRQ_IDX_W'(i);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rom_select_bit_o <= 1'b0;
      monitor_available_o <= 1'b0;
      start_addr_o <= PM_START_ZERO;
      boot_load_o <= 1'b0;
      peripheral_interrupt_line_o <= 1'b0;
      irq_pending_o <= 1'b0;
      irq_index_o <= '0;
      instruction_clock_out_o <= 1'b0;
      periph_clk_en_o <= 1'b1;
      watchdog_clk_en_o <= 1'b1;
    end
    else if (ce_i)
    begin
      rom_select_bit_o <= rom_select_bit;
      monitor_available_o <= rom_select_bit; // RULE_18
      start_addr_o <= standalone ? PM_ROM_BASE : PM_START_ZERO; // RULE_04
      boot_load_o <= !ram_high; // RULE_03 RULE_05
      peripheral_interrupt_line_o <= |periph_irq_src_i; // RULE_13
      irq_pending_o <= |eligible;
      irq_index_o <= next_irq_index;
      // toggles every instruction cycle; the pin is clk_sys_i divided
      instruction_clock_out_o <= clock_output_disable ? 1'b0 : !instruction_clock_out_o; // RULE_14 RULE_16
      periph_clk_en_o <= !clock_output_disable; // RULE_15 RULE_16
      watchdog_clk_en_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i || !ce_i);

  logic [WAIT_W:0] ext_cycles;
  logic [WAIT_W-1:0] exp_wait;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ext_cycles <= '0;
      exp_wait <= WAIT_ZERO;
    end
    else if (ce_i)
    begin
      if (take)
      begin
        ext_cycles <= '0;
        exp_wait <= sel_wait;
      end
      else if (state == ST_EXT)
        ext_cycles <= ext_cycles + (WAIT_W+1)'(1);
    end
  end

  sequence pm_ext_start;
    take && sel_is_pm && sel_ext && program_wait_count == WAIT_RESET;
  endsequence
  sequence pm_strobe_full;
    !ext_bus_o.pms_n [*8] ##1 ext_bus_o.pms_n;
  endsequence

  rom_default_a: assert property ((state == ST_INIT && standalone) |=> rom_select_bit) // RULE_02
    else $error("rom select not set in standalone start");
  monitor_zero_a: assert property ((state == ST_INIT && standalone) // RULE_11
    |=> (data_wait_register & DATA_WAIT_FIELDS) == '0)
    else $error("standalone start left data wait fields nonzero");
  rom_route_a: assert property ((take && sel_is_pm && in_range(sa, PM_ROM_BASE, PM_ROM_LAST) && !ram_high) // RULE_01
    |=> target_o == (rom_select_bit ? TGT_PM_ROM : TGT_PM_EXT))
    else $error("rom range routed to wrong target");
  pm_wait_seven_a: assert property (pm_ext_start |=> pm_strobe_full) // RULE_07
    else $error("program strobe not eight cycles for seven waits");
  strobe_len_a: assert property ((state == ST_EXT && wait_last) |-> ext_cycles == {1'b0, exp_wait}) // RULE_20
    else $error("external strobe length differs from wait count");
  internal_quiet_a: assert property ((take && !sel_ext) // RULE_19
    |=> ack_o && ext_bus_o.pms_n && ext_bus_o.dms_n && ext_bus_o.rd_n && ext_bus_o.wr_n
        && !ext_bus_o.addr_oe && !ext_bus_o.data_oe)
    else $error("internal access drove external pins");
  high_ram_a: assert property ((take && sel_is_pm && ram_high && sa >= PM_RAM_HIGH_BASE) // RULE_05
    |=> target_o == TGT_PM_RAM)
    else $error("top of program space not internal ram");
  periph_decode_a: assert property ((take && !sel_is_pm && dm_periph_hit) // RULE_08
    |=> target_o == TGT_DM_PERIPH && ext_bus_o.dms_n)
    else $error("peripheral block not decoded internally");
  nmi_a: assert property (core_irq_src_i[IRQ_PWRDN_IDX] |=> irq_pending_o) // RULE_12
    else $error("power-down interrupt was masked");
  periph_merge_a: assert property ((|periph_irq_src_i) ##1 core_irq_mask_i[IRQ_PERIPH_IDX] |=> irq_pending_o) // RULE_13
    else $error("peripheral source did not reach the core");
  clk_stop_a: assert property (clock_output_disable |=> !instruction_clock_out_o && !periph_clk_en_o) // RULE_16
    else $error("clock output disable did not stop clocks");
  vector_a: assert property ((take && sel_is_pm && sa < PM_USER_BASE) |=> vector_space_o) // RULE_06
    else $error("vector table access not flagged");

endmodule

`default_nettype wire

/* verilog/map_select_pin_pkg.sv */
/*
  Constants, types and helpers shared by the memory map and wait-state decoder.
  Assumes a core that issues one program or data access at a time and a single
  instruction-rate clock.
*/
// Behaviour
// (RULE_01) ROM select routes ROM range on-chip, else external
// (RULE_02) ROM select resets zero, one in standalone
// (RULE_03) both pins low: low RAM, boot, start zero
// (RULE_04) both pins high: same map, start in ROM
// (RULE_05) map high boot low: RAM at top, no boot
// (RULE_06) vector table low, user code from 0x060
// (RULE_07) program waits zero to seven, reset seven
// (RULE_08) data RAM, peripheral and core blocks decoded
// (RULE_09) five data wait fields reset to seven
// (RULE_10) software keeps peripheral wait field at zero
// (RULE_11) standalone start zeroes all data wait fields
// (RULE_12) interrupts prioritised and maskable, power-down not
// (RULE_13) peripheral sources merged onto one interrupt line
// (RULE_14) instruction clock twice the input clock rate; instruction_clock_out_o runs at half the clk_sys_i rate
// (RULE_15) peripherals run at instruction clock rate
// (RULE_16) clock output disable stops clock and peripherals
// (RULE_17) input clock runs continuously, never halted
// (RULE_18) monitor and debugger only with ROM select
// (RULE_19) internal accesses keep external pins idle
// (RULE_20) strobe stretched by exactly the wait count
package map_select_pin_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int PM_DATA_W = 24;
  localparam int DM_DATA_W = 16;
  localparam int DM_LANE_LSB = 8;
  localparam int WAIT_W = 3;
  localparam int N_PERIPH_IRQ = 11;
  localparam int N_CORE_IRQ = 10;
  localparam int IRQ_IDX_W = 4;

  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] AUTOBUF_CTRL_ADDR = 14'h3FF3;
  localparam logic [ADDR_W-1:0] DATA_WAIT_ADDR = 14'h3FFE;
  localparam logic [ADDR_W-1:0] SYS_CTRL_ADDR = 14'h3FFF;
  localparam int DW_A_LSB = 0;
  localparam int DW_B_LSB = 3;
  localparam int DW_C_LSB = 6;
  localparam int DW_D_LSB = 9;
  localparam int DW_E_LSB = 12;
  localparam int ROM_SEL_BIT = 15;
  localparam int PROGRAM_WAIT_COUNT_LSB = 0;
  localparam int CLOCK_OUTPUT_DISABLE_BIT = 14;
  localparam logic [DM_DATA_W-1:0] DATA_WAIT_RESET = 16'h7FFF;
  localparam logic [DM_DATA_W-1:0] DATA_WAIT_FIELDS = 16'h7FFF;
  localparam logic [DM_DATA_W-1:0] ROM_SEL_ONLY = 16'h8000;
  localparam logic [DM_DATA_W-1:0] AUTOBUF_RESET = 16'h0000;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 3'h0;
  localparam logic [WAIT_W-1:0] WAIT_STEP = 3'h1;

  // ----------------------------------------------------------------
  // program and data memory map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_TOP = 14'h3FFF;
  localparam logic [ADDR_W-1:0] PM_RAM_LOW_BASE = 14'h0000;
  localparam logic [ADDR_W-1:0] PM_RAM_LOW_LAST = 14'h07FF;
  localparam logic [ADDR_W-1:0] PM_ROM_BASE = 14'h0800;
  localparam logic [ADDR_W-1:0] PM_ROM_LAST = 14'h0FFF;
  localparam logic [ADDR_W-1:0] PM_EXT_LOW_BASE = 14'h1000;
  localparam logic [ADDR_W-1:0] PM_RAM_HIGH_BASE = 14'h3800;
  localparam logic [ADDR_W-1:0] PM_VECTOR_LAST = 14'h005F;
  localparam logic [ADDR_W-1:0] PM_USER_BASE = 14'h0060;
  localparam logic [ADDR_W-1:0] PM_START_ZERO = 14'h0000;
  localparam logic [ADDR_W-1:0] DM_PERIPH_BASE = 14'h2000;
  localparam logic [ADDR_W-1:0] DM_PERIPH_LAST = 14'h23FF;
  localparam logic [ADDR_W-1:0] DM_RAM_BASE = 14'h3800;
  localparam logic [ADDR_W-1:0] DM_RAM_LAST = 14'h3BFF;
  localparam logic [ADDR_W-1:0] DM_CORE_BASE = 14'h3C00;
  localparam logic [ADDR_W-1:0] DM_WAIT_B_BASE = 14'h0800;
  localparam logic [ADDR_W-1:0] DM_WAIT_D_BASE = 14'h1000;
  localparam logic [ADDR_W-1:0] DM_WAIT_C_BASE = 14'h2000;
  localparam logic [ADDR_W-1:0] DM_WAIT_E_BASE = 14'h2800;
  localparam logic [ADDR_W-1:0] DM_EXT_TOP = 14'h37FF;

  // ----------------------------------------------------------------
  // interrupts and timing
  // ----------------------------------------------------------------
  localparam int IRQ_PERIPH_IDX = 1;
  localparam int IRQ_PWRDN_IDX = 9;
  localparam logic [N_CORE_IRQ-1:0] NMI_MASK = 10'h200;
  localparam int INSTR_PERIOD_NS = 100;
  localparam int INPUT_PER_INSTR = 2;
  localparam int INPUT_PERIOD_NS = INPUT_PER_INSTR * INSTR_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_BOOT_PARALLEL = 2'b00,
    MODE_UNDEFINED = 2'b01,
    MODE_NO_BOOT = 2'b10,
    MODE_STANDALONE = 2'b11
  } map_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXT = 2'b01,
    ST_INIT = 2'b10
  } acc_state_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_PM_RAM = 3'b001,
    TGT_PM_ROM = 3'b010,
    TGT_PM_EXT = 3'b011,
    TGT_DM_RAM = 3'b100,
    TGT_DM_PERIPH = 3'b101,
    TGT_DM_CORE = 3'b110,
    TGT_DM_EXT = 3'b111
  } target_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [PM_DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic pms_n;
    logic dms_n;
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] addr;
    logic addr_oe;
    logic [PM_DATA_W-1:0] data;
    logic data_oe;
  } ext_bus_t;

  localparam mem_req_t REQ_NONE = '{valid: 1'b0, write: 1'b0, addr: '0, wdata: '0};
  localparam ext_bus_t EXT_IDLE = '{pms_n: 1'b1, dms_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                    addr: '0, addr_oe: 1'b0, data: '0, data_oe: 1'b0};

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

/* verilog/wait_state_counter.sv */
/*
  Down-counter that times how long an external strobe stays active.
  Assumes the caller loads it in the cycle the strobe is raised.
*/
`timescale 1ns/100ps
`default_nettype none

module wait_state_counter
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [map_select_pin_pkg::WAIT_W-1:0] count_i,
  output logic last_o
);
  import map_select_pin_pkg::*;

  logic [WAIT_W-1:0] remaining;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      remaining <= WAIT_ZERO;
    else if (ce_i)
    begin
      if (load_i)
        remaining <= count_i;
      else if (remaining != WAIT_ZERO)
        remaining <= remaining - WAIT_STEP; // RULE_20
    end
  end

  assign last_o = (remaining == WAIT_ZERO);

  count_load_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i || !ce_i) // RULE_20
    load_i |=> remaining == $past(count_i))
    else $error("wait counter did not load the wait count");

endmodule

`default_nettype wire

/* verif/ext_mem_model.sv */
/*
  External program and data memory seen through the decoder's bus.
  Assumes active-low strobes and at most one access at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module ext_mem_model
(
  input wire logic clk_sys_i,
  input wire map_select_pin_pkg::ext_bus_t bus_i,
  output logic [map_select_pin_pkg::PM_DATA_W-1:0] data_o
);
  import map_select_pin_pkg::*;
  logic [PM_DATA_W-1:0] mem [0:16383];
  logic flip = 1'b0;
  wire logic sel = !(bus_i.pms_n && bus_i.dms_n);
  // ----------------------------------------------------------------
  // storage and read path
  // ----------------------------------------------------------------
  // a released bus toggles, so a stale value is never taken as read data
  always @(posedge clk_sys_i)
  begin
    flip <= ~flip;
    if (sel && !bus_i.wr_n)
      mem[bus_i.addr] <= bus_i.data;
  end
  assign data_o = (sel && !bus_i.rd_n) ? mem[bus_i.addr] : {PM_DATA_W{flip}};
endmodule

`default_nettype wire

/* verif/memory_map_wait_state_decoder_test.sv */
/*
  Self-checking bench for the memory map and wait-state decoder.
  Assumes the external memory model answers every strobed access.
*/
`timescale 1ns/100ps
`default_nettype none

module memory_map_wait_state_decoder_test;
  import map_select_pin_pkg::*;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, map_pin = 1'b0, boot_pin = 1'b0, ce = 1'b1;
  mem_req_t pm_req = REQ_NONE, dm_req = REQ_NONE;
  logic [10:0] psrc = '0;
  logic [9:0] csrc = '0, cmask = '0;
  logic [23:0] ext_data, rdata, v;
  ext_bus_t bus;
  target_t tgt;
  logic busy, ack, rsel, mon, bootl, pline, ipend, clko, pclk, wclk, vsp;
  logic [13:0] start, a;
  logic [3:0] iidx;
  int n_mismatch = 0, check_count = 0, seed = 32'h5d81, cyc = 0, lat, stb, w, k;
  logic [13:0] da [4] = '{14'h3800, 14'h3BFF, 14'h2000, 14'h3C00};
  target_t dt [4] = '{TGT_DM_RAM, TGT_DM_RAM, TGT_DM_PERIPH, TGT_DM_CORE};

  memory_map_wait_state_decoder dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce),
    .map_select_pin_i(map_pin), .boot_select_pin_i(boot_pin), .pm_req_i(pm_req), .dm_req_i(dm_req),
    .ext_data_i(ext_data), .periph_irq_src_i(psrc), .core_irq_src_i(csrc), .core_irq_mask_i(cmask),
    .ext_bus_o(bus), .busy_o(busy), .ack_o(ack), .rdata_o(rdata), .target_o(tgt), .vector_space_o(vsp),
    .rom_select_bit_o(rsel), .monitor_available_o(mon), .start_addr_o(start), .boot_load_o(bootl),
    .peripheral_interrupt_line_o(pline), .irq_pending_o(ipend), .irq_index_o(iidx),
    .instruction_clock_out_o(clko), .periph_clk_en_o(pclk), .watchdog_clk_en_o(wclk));
  ext_mem_model mem (.clk_sys_i(clk_sys_i), .bus_i(bus), .data_o(ext_data));

  // clock never stops, even across resets
  initial forever #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rst(input logic m, input logic b);
    @(posedge clk_sys_i);
    map_pin <= m;
    boot_pin <= b;
    resetn_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
  endtask
  // lat counts edges from the driving edge to ack; stb counts cycles with pins active
  task automatic acc(input logic dm, input logic wr, input logic [13:0] ad, input logic [23:0] d);
    @(posedge clk_sys_i);
    if (dm)
      dm_req <= '{valid: 1'b1, write: wr, addr: ad, wdata: d};
    else
      pm_req <= '{valid: 1'b1, write: wr, addr: ad, wdata: d};
    stb = 0;
    @(posedge clk_sys_i);
    pm_req <= REQ_NONE;
    dm_req <= REQ_NONE;
    for (lat = 1; lat < 20; lat++)
    begin
      #1;
      if (!bus.pms_n || !bus.dms_n || bus.addr_oe || bus.data_oe)
        stb++;
      if (ack === 1'b1)
        break;
      @(posedge clk_sys_i);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // an external access with n waits acks n + 2 edges after the driving edge
  function automatic logic [23:0] exp_lat(input int n);
    return 24'(n + 2);
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst(1'b0, 1'b0);
    chk("start", 24'h0, 24'(start));
    chk("boot", 24'h1, 24'(bootl));
    chk("idle", 24'h0, 24'({busy, ack}));
    acc(1'b1, 1'b0, DATA_WAIT_ADDR, 24'h0);
    chk("dwait reset", 24'h7FFF, rdata);
    chk("romsel", 24'h0, 24'(rsel));
    acc(1'b0, 1'b0, 14'h1000, 24'h0);
    chk("program_wait_count 7 lat", 24'd9, 24'(lat));
    chk("program_wait_count 7 stb", 24'd8, 24'(stb));
    for (w = 0; w < 8; w++)
    begin
      a = 14'h1000 + 14'($random(seed) & 32'hFFF);
      v = 24'($random(seed));
      acc(1'b1, 1'b1, SYS_CTRL_ADDR, 24'(w));
      acc(1'b0, 1'b1, a, v);
      chk("wr stb", 24'(w + 1), 24'(stb));
      acc(1'b0, 1'b0, a, 24'h0);
      chk("rd lat", exp_lat(w), 24'(lat));
      chk("rd data", v, rdata);
    end
    $display("program wait test done");
    acc(1'b1, 1'b1, DATA_WAIT_ADDR, 24'h8000);
    acc(1'b0, 1'b0, PM_ROM_BASE, 24'h0);
    chk("rom tgt", 24'(TGT_PM_ROM), 24'(tgt));
    chk("monitor", 24'h1, 24'(mon));
    acc(1'b1, 1'b1, DATA_WAIT_ADDR, 24'h0);
    acc(1'b0, 1'b0, PM_ROM_BASE, 24'h0);
    chk("rom off tgt", 24'(TGT_PM_EXT), 24'(tgt));
    acc(1'b0, 1'b0, PM_VECTOR_LAST, 24'h0);
    chk("vector", 24'h1, 24'(vsp));
    chk("int pins", 24'h0, 24'(stb));
    acc(1'b0, 1'b0, PM_USER_BASE, 24'h0);
    chk("user", 24'h0, 24'(vsp));
    for (k = 0; k < 4; k++)
    begin
      acc(1'b1, 1'b0, da[k], 24'h0);
      chk("dm tgt", 24'(dt[k]), 24'(tgt));
      chk("dm pins", 24'h0, 24'(stb));
    end
    $display("map test done");
    k = {$random(seed)} % 11;
    psrc <= 11'h1 << k;
    tick(3);
    chk("pline", 24'h1, 24'(pline));
    chk("masked", 24'h0, 24'(ipend));
    cmask <= 10'h002;
    tick(3);
    chk("irq idx", 24'h11, 24'({ipend, iidx}));
    psrc <= '0;
    cmask <= '0;
    csrc <= 10'h200;
    tick(3);
    chk("pwrdn", 24'h19, 24'({ipend, iidx}));
    csrc <= '0;
    $display("interrupt test done");
    tick(1);
    v = 24'(clko);
    tick(1);
    chk("clko", {23'h0, ~v[0]}, 24'(clko));
    chk("pclk", 24'h1, 24'(pclk));
    ce <= 1'b0;
    v = 24'(clko);
    tick(3);
    chk("ce hold", v, 24'(clko));
    ce <= 1'b1;
    acc(1'b1, 1'b1, AUTOBUF_CTRL_ADDR, 24'h4000);
    tick(2);
    chk("clko off", 24'h0, 24'({clko, pclk}));
    chk("wdog", 24'h1, 24'(wclk));
    $display("clock test done");
    rst(1'b1, 1'b1);
    chk("sa start", 24'h0800, 24'(start));
    acc(1'b1, 1'b0, DATA_WAIT_ADDR, 24'h0);
    chk("sa dwait", 24'h8000, rdata);
    chk("sa rom", 24'h3, 24'({rsel, mon}));
    rst(1'b1, 1'b0);
    chk("nb boot", 24'h0, 24'({bootl, start}));
    acc(1'b0, 1'b0, PM_RAM_HIGH_BASE, 24'h0);
    chk("nb ram", 24'(TGT_PM_RAM), 24'(tgt));
    a = 14'($random(seed) & 32'h7FF);
    v = {8'h0, 16'($random(seed))};
    acc(1'b1, 1'b1, a, v);
    acc(1'b1, 1'b0, a, 24'h0);
    chk("dm lat", 24'd9, 24'(lat));
    chk("dm data", v, rdata);
    $display("strap test done");
    end_sim();
  end
endmodule

`default_nettype wire
